// ==== hw/sru_pkg.sv ====
// Shared constants and types for the serial receiver unit.
package sru_pkg;
    localparam int ADDR_W = 12;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } sru_apb_req_t;

    // Control register layout, bit 12 down to bit 0.
    typedef struct packed {
        logic double_speed_select;
        logic mp_format;
        logic two_stop;
        logic parity_odd;
        logic parity_en;
        logic seven_bit;
        logic sync_mode;
        logic clock_select_hi;
        logic clock_select_lo;
        logic id_wait_enable;
        logic rx_irq_enable;
        logic tx_en;
        logic rx_en;
    } sru_ctrl_t;

    localparam int CTRL_W = 13;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_RXDATA = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_TXDATA = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_BAUD = 12'h010;

    localparam int ST_TDR_EMPTY = 0;
    localparam int ST_TX_END = 1;
    localparam int ST_PARITY = 2;
    localparam int ST_FRAMING = 3;
    localparam int ST_OVERRUN = 4;
    localparam int ST_RX_FULL = 5;
    localparam int ST_RX_ID = 6;
    localparam int ST_TX_ID = 7;

    localparam sru_ctrl_t CTRL_RESET = '0;
    localparam logic [15:0] BAUD_RESET = 16'h0000;
    localparam logic [4:0] OVS_NORMAL = 5'h10;
    localparam logic [4:0] OVS_DOUBLE = 5'h08;
    localparam logic [3:0] SYNC_BITS = 4'h8;
endpackage

// ==== hw/sru_top.sv ====
// Serial receiver unit with multiprocessor and clocked synchronous modes.
//
// Contract
// - Start bit syncs, shifts frame, checks parity, stop.
// - Frame while full: set overrun, drop byte.
// - Parity mismatch sets flag, byte still stored.
// - Stop bit zero sets framing flag, byte stored.
// - Good frame stores byte, sets full, irq.
// - Any error with enable raises error irq.
// - Receive errors leave full flag unchanged.
// - No new frames while error flags set.
// - Overrun combos lose byte; others deliver it.
// - Extra bit one marks ID, zero data.
// - ID-wait suppresses transfer, errors, flags until ID.
// - ID frame sets ID bit, clears ID-wait.
// - Multiprocessor format ignores parity enable.
// - Transmit-ID bit is sent as extra bit.
// - Synchronous character is eight bits, no extras.
// - Synchronous transmit changes on falling clock edge.
// - Synchronous receive samples on rising clock edge.
// - After eighth bit, line holds the MSB.
// - Clock-select high bit picks internal or external clock.
// - Internal clock: eight pulses, idle high.
// - Independent double-buffered transmitter and receiver.
// - Sixteen or eight times base clock, mid-bit sampling.
// - Start, 7/8 data, optional extra, 1/2 stops.
`timescale 1ns/1ns
module sru_top (
    input wire logic SYS_CLK_IN,
    input wire logic RESETN_IN,
    input wire sru_pkg::sru_apb_req_t APB_REQ_IN,
    output logic [31:0] APB_PRDATA_OUT,
    output logic APB_PREADY_OUT,
    output logic APB_PSLVERR_OUT,
    input wire logic RXD_IN,
    output logic TXD_OUT,
    input wire logic SCK_IN,
    output logic SCK_OUT,
    output logic SCK_OE_N_OUT,
    output logic RX_DATA_IRQ_OUT,
    output logic RX_ERROR_IRQ_OUT
);
    import sru_pkg::*;

    function automatic logic [3:0] data_bits(input sru_ctrl_t c);
        return c.seven_bit ? 4'h7 : 4'h8;
    endfunction

    function automatic logic has_extra(input sru_ctrl_t c);
        return c.mp_format | c.parity_en;
    endfunction

    // Parity over the active data bits; odd selects odd parity.
    function automatic logic parity_of(input sru_ctrl_t c,
                                       input logic [7:0] d);
        logic p;
        p = c.parity_odd;
        for (int i = 0; i < 8; i++) begin
            if (i < 32'(data_bits(c))) begin
                p = p ^ d[i];
            end
        end
        return p;
    endfunction

    // Whole asynchronous frame, first bit on the line in bit 0.
    function automatic logic [11:0] build_frame(input sru_ctrl_t c,
                                                input logic [7:0] d,
                                                input logic received_id_bit);
        logic [11:0] f;
        logic [3:0] n;
        f = '1;
        n = data_bits(c);
        f[0] = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (i < 32'(n)) begin
                f[i + 1] = d[i];
            end
        end
        if (c.mp_format) begin
            f[n + 4'h1] = received_id_bit;
        end else if (c.parity_en) begin
            f[n + 4'h1] = parity_of(c, d);
        end
        return f;
    endfunction

    logic [1:0] rst_sync;
    logic rst_n;
    logic rxd_meta, rxd_s, rxd_d;
    logic sck_meta, sck_s, sck_d;
    sru_ctrl_t ctrl;
    logic [15:0] baud_div, int_cnt;
    logic [7:0] tdr, receive_data_reg, tsr;
    logic tdr_full, tx_end, tx_id_bit;
    logic parity_error_flag, framing_error_flag, overrun_flag, rx_full, rx_id;
    logic [31:0] prdata;
    logic rx_data_irq, rx_error_irq;
    logic [11:0] tx_sh;
    logic [3:0] tx_left;
    logic [4:0] tx_phase;
    logic txd, s_tx;
    logic ar_busy, ar_start;
    logic [4:0] ar_phase;
    logic [3:0] ar_idx;
    logic [11:0] ar_vec;
    logic s_active, sck_int;
    logic [3:0] s_cnt;
    logic [7:0] sr_sh;

    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Both pins come from outside; the second and third stages are read, the first never.
    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            {rxd_meta, rxd_s, rxd_d} <= 3'b111;
            {sck_meta, sck_s, sck_d} <= 3'b111;
        end else begin
            {rxd_meta, rxd_s, rxd_d} <= {RXD_IN, rxd_meta, rxd_s};
            {sck_meta, sck_s, sck_d} <= {SCK_IN, sck_meta, sck_s};
        end
    end

    logic sck_rise, sck_fall, rxd_fall, int_tick, base_tick, ext_clk;
    logic rx_err;
    logic [4:0] ovs, half;
    assign sck_rise = sck_s & ~sck_d;
    assign sck_fall = ~sck_s & sck_d;
    assign rxd_fall = ~rxd_s & rxd_d;
    assign ext_clk = ctrl.clock_select_hi;
    assign int_tick = (int_cnt == baud_div);
    assign base_tick = ext_clk ? sck_rise : int_tick;
    assign ovs = ctrl.double_speed_select ? OVS_DOUBLE : OVS_NORMAL;
    assign half = ovs >> 1;
    assign rx_err = parity_error_flag | framing_error_flag | overrun_flag;

    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            int_cnt <= 16'h0000;
        end else if (int_tick) begin
            int_cnt <= 16'h0000;
        end else begin
            int_cnt <= int_cnt + 16'h0001;
        end
    end

    // APB decode; zero wait states, unmapped offsets answer with pslverr.
    logic wr_en, setup, addr_ok;
    logic [ADDR_W-1:0] addr;
    assign addr = APB_REQ_IN.paddr;
    assign wr_en = APB_REQ_IN.psel & APB_REQ_IN.penable & APB_REQ_IN.pwrite;
    assign setup = APB_REQ_IN.psel & ~APB_REQ_IN.penable;
    assign addr_ok = addr == OFS_CTRL || addr == OFS_STATUS ||
        addr == OFS_RXDATA || addr == OFS_TXDATA || addr == OFS_BAUD;
    assign APB_PREADY_OUT = 1'b1;
    assign APB_PSLVERR_OUT = APB_REQ_IN.psel & APB_REQ_IN.penable & ~addr_ok;
    assign APB_PRDATA_OUT = prdata;

    logic [7:0] status;
    assign status = {tx_id_bit, rx_id, rx_full, overrun_flag, framing_error_flag, parity_error_flag, tx_end,
                     ~tdr_full};

    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            case (addr)
                OFS_CTRL: prdata <= {19'h0, ctrl};
                OFS_STATUS: prdata <= {24'h0, status};
                OFS_RXDATA: prdata <= {24'h0, receive_data_reg};
                OFS_TXDATA: prdata <= {24'h0, tdr};
                OFS_BAUD: prdata <= {16'h0, baud_div};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Synchronous clock engine: falls shift out, rises sample in.
    logic s_start_ok, s_first, s_fall, s_rise, s_end, tx_take;
    assign s_start_ok = ~rx_err & ((ctrl.tx_en & tdr_full) |
        (ctrl.rx_en & ~ctrl.tx_en));
    assign s_first = ctrl.sync_mode & ~s_active & s_start_ok &
        (ext_clk ? sck_fall : 1'b1);
    assign s_fall = s_first | (ctrl.sync_mode & s_active &
        (ext_clk ? sck_fall : (int_tick & sck_int & s_cnt != SYNC_BITS)));
    assign s_rise = ctrl.sync_mode & s_active &
        (ext_clk ? sck_rise : (int_tick & ~sck_int));
    assign s_end = ctrl.sync_mode & s_active & (ext_clk ?
        (sck_rise & s_cnt == SYNC_BITS - 4'h1) :
        (int_tick & sck_int & s_cnt == SYNC_BITS));

    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            s_active <= 1'b0;
            s_cnt <= 4'h0;
            sck_int <= 1'b1;
        end else if (!ctrl.sync_mode) begin
            s_active <= 1'b0;
            sck_int <= 1'b1;
        end else if (s_first) begin
            s_active <= 1'b1;
            s_cnt <= 4'h0;
            sck_int <= 1'b0;
        end else if (s_end) begin
            s_active <= 1'b0;
            sck_int <= 1'b1;
        end else if (s_rise) begin
            s_cnt <= s_cnt + 4'h1;
            sck_int <= 1'b1;
        end else if (s_fall) begin
            sck_int <= 1'b0;
        end
    end

    // The pin is driven only for synchronous mode on the internal clock.
    assign SCK_OE_N_OUT = ~(ctrl.sync_mode & ~ext_clk);
    assign SCK_OUT = sck_int;

    // Transmitter.
    assign tx_take = ctrl.sync_mode ? (s_first & ctrl.tx_en & tdr_full) :
        (ctrl.tx_en & tdr_full & tx_left == 4'h0 & ~rx_err);

    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            txd <= 1'b1;
            tsr <= 8'h00;
            s_tx <= 1'b0;
            tx_sh <= '1;
            tx_left <= 4'h0;
            tx_phase <= 5'h00;
        end else if (ctrl.sync_mode) begin
            tx_left <= 4'h0;
            if (s_first) begin
                s_tx <= tx_take;
                if (tx_take) begin
                    tsr <= tdr;
                    txd <= tdr[0];
                end
            end else if (s_fall && s_tx) begin
                txd <= tsr[s_cnt[2:0]];
            end else if (s_end) begin
                s_tx <= 1'b0;
            end
        end else if (tx_take) begin
            tx_sh <= build_frame(ctrl, tdr, tx_id_bit);
            tx_left <= 4'h2 + data_bits(ctrl) + {3'h0, has_extra(ctrl)} +
                {3'h0, ctrl.two_stop};
            tx_phase <= 5'h00;
            txd <= 1'b0;
        end else if (tx_left != 4'h0 && base_tick) begin
            if (tx_phase == ovs - 5'h01) begin
                tx_phase <= 5'h00;
                tx_sh <= {1'b1, tx_sh[11:1]};
                txd <= tx_left == 4'h1 ? 1'b1 : tx_sh[1];
                tx_left <= tx_left - 4'h1;
            end else begin
                tx_phase <= tx_phase + 5'h01;
            end
        end
    end
    assign TXD_OUT = txd;

    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            tx_end <= 1'b1;
        end else begin
            tx_end <= ~tdr_full & (ctrl.sync_mode ? ~s_tx : tx_left == 4'h0);
        end
    end

    // Transmit buffer: software fills it while the shifter is busy.
    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            tdr <= 8'h00;
            tdr_full <= 1'b0;
        end else if (wr_en && addr == OFS_TXDATA) begin
            tdr <= APB_REQ_IN.pwdata[7:0];
            tdr_full <= 1'b1;
        end else if (tx_take) begin
            tdr_full <= 1'b0;
        end
    end

    // Asynchronous receiver sampling at mid-bit.
    logic ar_sample, ar_done;
    logic [3:0] ar_need;
    logic [11:0] ar_full;
    assign ar_need = data_bits(ctrl) + {3'h0, has_extra(ctrl)} + 4'h1;
    assign ar_sample = ar_busy & base_tick & ar_phase == half - 5'h01;
    assign ar_done = ar_sample & ~ar_start & ar_idx == ar_need - 4'h1;

    always_comb begin
        ar_full = ar_vec;
        ar_full[ar_idx] = rxd_s;
    end

    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            ar_busy <= 1'b0;
            ar_start <= 1'b0;
            ar_phase <= 5'h00;
            ar_idx <= 4'h0;
            ar_vec <= 12'h000;
        end else if (!ctrl.rx_en || ctrl.sync_mode) begin
            ar_busy <= 1'b0;
        end else if (!ar_busy) begin
            if (rxd_fall && !rx_err) begin
                ar_busy <= 1'b1;
                ar_start <= 1'b1;
                ar_phase <= 5'h00;
                ar_idx <= 4'h0;
            end
        end else if (base_tick) begin
            ar_phase <= ar_phase == ovs - 5'h01 ? 5'h00 : ar_phase + 5'h01;
            if (ar_sample) begin
                if (ar_start) begin
                    ar_start <= 1'b0;
                    ar_busy <= ~rxd_s;
                end else begin
                    ar_vec[ar_idx] <= rxd_s;
                    ar_idx <= ar_idx + 4'h1;
                    ar_busy <= ar_idx != ar_need - 4'h1;
                end
            end
        end
    end

    // Synchronous receiver, eight bits LSB first.
    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            sr_sh <= 8'h00;
        end else if (s_rise) begin
            sr_sh <= {rxd_s, sr_sh[7:1]};
        end
    end

    logic sync_done, rx_done, rx_mp, rx_perr, rx_ferr;
    logic [7:0] rx_data;
    logic [3:0] nb;
    assign nb = data_bits(ctrl);
    assign sync_done = s_end & ctrl.rx_en & ~rx_err;
    assign rx_done = ar_done | sync_done;

    always_comb begin
        rx_data = ctrl.seven_bit ? {1'b0, ar_full[6:0]} : ar_full[7:0];
        rx_mp = ctrl.mp_format & ar_full[nb];
        rx_perr = ctrl.parity_en & ~ctrl.mp_format &
            (ar_full[nb] != parity_of(ctrl, rx_data));
        rx_ferr = ~ar_full[nb + {3'h0, has_extra(ctrl)}];
        // On the internal clock the end comes one tick after the eighth
        // rise, so the shifter already holds the whole character then.
        if (sync_done) begin
            rx_data = ext_clk ? {rxd_s, sr_sh[7:1]} : sr_sh;
            rx_mp = 1'b0;
            rx_perr = 1'b0;
            rx_ferr = 1'b0;
        end
    end

    // Status flags; a hardware set always beats a software clear.
    logic wait_skip, take, id_hit, st_wr, load;
    logic [7:0] wd;
    assign wait_skip = ctrl.id_wait_enable & ctrl.mp_format & ~ctrl.sync_mode;
    assign take = rx_done & ~(wait_skip & ~rx_mp);
    assign id_hit = rx_done & wait_skip & rx_mp;
    assign load = take & ~rx_full;
    assign st_wr = wr_en && addr == OFS_STATUS;
    assign wd = st_wr ? APB_REQ_IN.pwdata[7:0] : 8'hff;

    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            {parity_error_flag, framing_error_flag, overrun_flag, rx_full, rx_id} <= 5'b00000;
            tx_id_bit <= 1'b0;
            receive_data_reg <= 8'h00;
        end else begin
            overrun_flag <= (overrun_flag & wd[ST_OVERRUN]) | (take & rx_full);
            parity_error_flag <= (parity_error_flag & wd[ST_PARITY]) | (take & rx_perr);
            framing_error_flag <= (framing_error_flag & wd[ST_FRAMING]) | (take & rx_ferr);
            rx_full <= (rx_full & wd[ST_RX_FULL]) |
                (load & ~rx_perr & ~rx_ferr);
            if (load) begin
                receive_data_reg <= rx_data;
            end
            if (take && ctrl.mp_format) begin
                rx_id <= rx_mp;
            end else if (st_wr) begin
                rx_id <= rx_id & wd[ST_RX_ID];
            end
            if (st_wr) begin
                tx_id_bit <= wd[ST_TX_ID];
            end
        end
    end

    // A software write to control wins over the automatic ID-wait clear.
    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
        end else if (wr_en && addr == OFS_CTRL) begin
            ctrl <= sru_ctrl_t'(APB_REQ_IN.pwdata[CTRL_W-1:0]);
        end else if (id_hit) begin
            ctrl.id_wait_enable <= 1'b0;
        end
    end

    // Kept apart so that a divider write never swallows an ID-wait clear.
    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            baud_div <= BAUD_RESET;
        end else if (wr_en && addr == OFS_BAUD) begin
            baud_div <= APB_REQ_IN.pwdata[15:0];
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            rx_data_irq <= 1'b0;
            rx_error_irq <= 1'b0;
        end else begin
            rx_data_irq <= ctrl.rx_irq_enable & rx_full;
            rx_error_irq <= ctrl.rx_irq_enable & rx_err;
        end
    end
    assign RX_DATA_IRQ_OUT = rx_data_irq;
    assign RX_ERROR_IRQ_OUT = rx_error_irq;

    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!rst_n);

    overrun_drop_a: assert property (
        take && rx_full |=> overrun_flag && rx_full && $stable(receive_data_reg))
        else $error("overrun frame altered data or full flag");
    parity_store_a: assert property (
        take && rx_perr && !rx_full |=> parity_error_flag && receive_data_reg == $past(rx_data))
        else $error("parity error frame not stored");
    framing_store_a: assert property (
        take && rx_ferr && !rx_full |=> framing_error_flag && receive_data_reg == $past(rx_data))
        else $error("framing error frame not stored");
    good_frame_a: assert property (
        load && !rx_perr && !rx_ferr ##1 ctrl.rx_irq_enable |=>
        rx_data_irq)
        else $error("good frame did not raise data request");
    error_irq_a: assert property (
        ctrl.rx_irq_enable && (parity_error_flag || framing_error_flag || overrun_flag) ##1
        ctrl.rx_irq_enable |-> rx_error_irq)
        else $error("error flag without error request");
    full_keep_a: assert property (
        take && (rx_perr || rx_ferr) && !st_wr |=> rx_full == $past(rx_full))
        else $error("full flag changed on errored frame");
    err_block_a: assert property (
        rx_err && !ar_busy && !ctrl.sync_mode |=> !ar_busy)
        else $error("reception started with an error flag set");
    id_skip_a: assert property (
        rx_done && wait_skip && !rx_mp |=> $stable(receive_data_reg) &&
        $stable({rx_full, framing_error_flag, overrun_flag}) || $past(st_wr))
        else $error("skipped frame touched data or flags");
    id_hit_a: assert property (
        id_hit && !(wr_en && addr == OFS_CTRL) |=>
        rx_id && !ctrl.id_wait_enable)
        else $error("ID frame did not resume reception");
    sck_idle_a: assert property (
        ctrl.sync_mode && !ext_clk && !s_active |-> SCK_OUT)
        else $error("internal serial clock not high when idle");
    msb_hold_a: assert property (
        s_end && s_tx ##1 !s_fall [*3] |-> txd == tsr[7] && $stable(txd))
        else $error("line did not hold the last bit");
endmodule

// ==== tb/sru_remote.sv ====
// Remote serial station: sends frames and reads back transmitted ones.
`timescale 1ns/1ns
module sru_remote (
    output logic sck,
    output logic rxd,
    input wire logic txd
);
    // The base clock runs free, as an oscillator on the pin would.
    initial begin
        sck = 1'b1;
        rxd = 1'b1;
        #7;
        forever #32 sck = ~sck;
    end

    task automatic bit_time(input logic b);
        rxd <= b;
        repeat (16) @(posedge sck);
    endtask

    // Sends a start bit, n bits of d LSB first, one stop bit, then idle.
    task automatic send(input logic [8:0] d, input int n, input logic stp);
        int i;
        bit_time(1'b0);
        for (i = 0; i < n; i++) begin
            bit_time(d[i]);
        end
        bit_time(stp);
        bit_time(1'b1);
    endtask

    // Samples nine bits in the middle of each bit cell.
    task automatic recv(output logic [8:0] v);
        int i;
        @(negedge txd);
        repeat (8) @(posedge sck);
        for (i = 0; i < 9; i++) begin
            repeat (16) @(posedge sck);
            v[i] = txd;
        end
    endtask
endmodule

// ==== tb/tb_sru_top.sv ====
// Testbench for the serial receiver unit: registers and serial traffic.
`timescale 1ns/1ns
`define CHK(g, e) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        errors++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
end
module tb_sru_top;
    import sru_pkg::*;
    localparam logic [31:0] C_EXT = 32'h0000_0027;
    localparam logic [31:0] C_PAR = 32'h0000_0127;
    localparam logic [31:0] C_MP = 32'h0000_092f;
    localparam logic [31:0] C_INT = 32'h0000_0787;
    localparam logic [31:0] C_SYNC = 32'h0000_0043;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    sru_apb_req_t req = '0;
    logic [31:0] prdata;
    logic pready, pslverr, txd, rxd, ext_sck, sck_pin, sck_out, sck_oe_n;
    logic irq_d, irq_e;
    logic [32:0] exp_q[$];
    logic [32:0] msk_q[$];
    logic [32:0] e_now, m_now;
    int errors = 0;
    int tests_run = 0;
    int nrise = 0;
    logic [31:0] seed = 32'd72310;
    logic [7:0] sb, d1, d4, d5, d8;
    logic [8:0] v;

    always #2 clk = ~clk;
    // The pin carries the unit's clock only while its driver is enabled.
    assign sck_pin = sck_oe_n ? ext_sck : sck_out;

    sru_top dut (.SYS_CLK_IN(clk), .RESETN_IN(rst_n), .APB_REQ_IN(req),
        .APB_PRDATA_OUT(prdata), .APB_PREADY_OUT(pready),
        .APB_PSLVERR_OUT(pslverr), .RXD_IN(rxd), .TXD_OUT(txd),
        .SCK_IN(sck_pin), .SCK_OUT(sck_out), .SCK_OE_N_OUT(sck_oe_n),
        .RX_DATA_IRQ_OUT(irq_d), .RX_ERROR_IRQ_OUT(irq_e));
    sru_remote remote (.sck(ext_sck), .rxd(rxd), .txd(txd));

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        req <= '0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] e,
                      input logic [32:0] m = {33{1'b1}});
        exp_q.push_back(e);
        msk_q.push_back(m);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic frame(input logic [8:0] d, input int n, input logic stp);
        remote.send(d, n, stp);
        repeat (8) @(posedge clk);
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        if (req.psel && req.penable && !req.pwrite && pready === 1'b1) begin
            m_now = msk_q.pop_front();
            e_now = exp_q.pop_front();
            `CHK({pslverr, prdata} & m_now, e_now)
        end
    end

    always @(posedge sck_out) begin
        if (!sck_oe_n) begin
            sb = {txd, sb[7:1]};
            nrise++;
        end
    end

    initial begin
        #300000;
        errors++;
        finish_test();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(OFS_CTRL, 33'h0);
        rd(12'h020, {1'b1, 32'h0});
        wr(OFS_BAUD, 32'h0000_000f);
        wr(OFS_CTRL, C_EXT);
        d1 = rnd();
        frame({1'b0, d1}, 8, 1'b1);
        rd(OFS_STATUS, 33'h20, 33'hfc);
        rd(OFS_RXDATA, {25'h0, d1});
        `CHK({irq_d, irq_e}, 2'b10)
        frame({1'b0, rnd()}, 8, 1'b1);
        rd(OFS_STATUS, 33'h30, 33'hfc);
        rd(OFS_RXDATA, {25'h0, d1});
        `CHK({irq_d, irq_e}, 2'b11)
        frame({1'b0, rnd()}, 8, 1'b1);
        rd(OFS_RXDATA, {25'h0, d1});
        wr(OFS_STATUS, 32'h0);
        wr(OFS_CTRL, C_PAR);
        d4 = rnd();
        frame({~^d4, d4}, 9, 1'b0);
        rd(OFS_STATUS, 33'h0c, 33'hfc);
        rd(OFS_RXDATA, {25'h0, d4});
        `CHK(irq_e, 1'b1)
        wr(OFS_STATUS, 32'h0);
        d5 = rnd();
        frame({^d5, d5}, 9, 1'b1);
        v = {1'b0, rnd()};
        v[8] = ~^v[7:0];
        frame(v, 9, 1'b1);
        rd(OFS_STATUS, 33'h34, 33'hfc);
        rd(OFS_RXDATA, {25'h0, d5});
        wr(OFS_STATUS, 32'h0);
        wr(OFS_CTRL, C_MP);
        frame({1'b0, rnd()}, 9, 1'b1);
        rd(OFS_STATUS, 33'h0, 33'hfc);
        rd(OFS_RXDATA, {25'h0, d5});
        // Even parity would reject this ID, so an ignored setting shows.
        d8 = rnd();
        d8[7] = ^d8[6:0];
        frame({1'b1, d8}, 9, 1'b1);
        rd(OFS_STATUS, 33'h60, 33'hfc);
        rd(OFS_RXDATA, {25'h0, d8});
        rd(OFS_CTRL, {1'b0, C_MP & ~32'h8});
        `CHK(irq_d, 1'b1)
        wr(OFS_STATUS, 32'h0);
        d1 = rnd();
        frame({1'b0, d1}, 9, 1'b1);
        rd(OFS_STATUS, 33'h20, 33'hfc);
        rd(OFS_RXDATA, {25'h0, d1});
        wr(OFS_STATUS, 32'h80);
        d4 = rnd();
        fork
            remote.recv(v);
            wr(OFS_TXDATA, {24'h0, d4});
        join
        `CHK(v, {1'b1, d4})
        repeat (600) @(posedge clk);
        wr(OFS_CTRL, C_INT);
        // Seven data bits, odd parity and two stops on the internal clock.
        d5 = rnd();
        frame({1'b0, ~^d5[6:0], d5[6:0]}, 8, 1'b1);
        rd(OFS_STATUS, 33'h20, 33'h3c);
        rd(OFS_RXDATA, {26'h0, d5[6:0]});
        wr(OFS_STATUS, 32'h0);
        wr(OFS_CTRL, C_SYNC);
        d4 = rnd();
        d8 = rnd();
        remote.rxd <= d8[0];
        // Receive bits change on the unit's falling clock edges.
        fork
            wr(OFS_TXDATA, {24'h0, d4});
            begin
                @(negedge sck_out);
                for (int i = 1; i < 8; i++) begin
                    @(negedge sck_out);
                    remote.rxd <= d8[i];
                end
            end
        join
        while (nrise < 8) @(posedge clk);
        repeat (40) @(posedge clk);
        `CHK(sb, d4)
        `CHK(nrise, 8)
        `CHK({sck_out, sck_oe_n}, 2'b10)
        `CHK(txd, d4[7])
        rd(OFS_STATUS, 33'h20, 33'h3c);
        rd(OFS_RXDATA, {25'h0, d8});
        finish_test();
    end
endmodule
